// >>> rtl/i2c_status_map.vh
// register map and field positions of the i2c status flag block
// assumes byte-wide registers on a plain strobe port
`ifndef I2C_STATUS_MAP_VH
`define I2C_STATUS_MAP_VH
`define ADDR_BUS_STATUS    2'h0
`define ADDR_BUS_CONTROL   2'h1
`define ADDR_ROLE_CTRL     2'h2
`define ADDR_SHIFT_OUT     2'h3
`define BIT_STOP           0
`define BIT_START          1
`define BIT_ACK            2
`define BIT_DIR            3
`define BIT_WAIT_CANCEL    5
`define BIT_RELEASE        6
`define BIT_ENABLE         7
`define BIT_MASTER         0
`define BIT_ARB_LOST       1
`define CTRL_RESET         8'h00
`define BYTE_ZERO          8'h00
`define BIT_COUNT_FIRST    4'h1
`define BIT_COUNT_LSB      4'h8
`define BIT_COUNT_ACK      4'h9
`endif

// >>> rtl/i2c_status_flags.v
// status flag logic of an i2c bus interface: direction, ack, start, stop
// assumes bus pins arrive asynchronously and are synchronised here
`timescale 1ns/1ns
`include "i2c_status_map.vh"
module i2c_status_flags
(
  input  wire       clk_sys,
  input  wire       rstn,
  input  wire [1:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  input  wire       serial_clock_line,
  input  wire       serial_data_line_in,
  output reg        serial_data_line_out,
  output reg        serial_data_line_oe
);

  //----------------------------------------
  // pin synchronisers and edge detection
  //----------------------------------------
  reg  [1:0] scl_sync;
  reg  [1:0] sda_sync;
  reg        scl_prev;
  reg        sda_prev;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_cond;
  wire       stop_cond;

  // idle-high reset values, no false edge after reset
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], serial_clock_line};
      sda_sync <= {sda_sync[0], serial_data_line_in};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  assign scl_rise   = scl_sync[1] & ~scl_prev;
  assign scl_fall   = ~scl_sync[1] & scl_prev;
  assign start_cond = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
  assign stop_cond  = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];

  //----------------------------------------
  // decode helpers
  //----------------------------------------
  function reg_hit;
    input       strobe;
    input [1:0] index;
    input [1:0] target;
  begin
    reg_hit = strobe & (index == target);
  end
  endfunction

  function at_pos;
    input [3:0] cnt;
    input [3:0] pos;
  begin
    at_pos = (cnt == pos - 4'h1);
  end
  endfunction

  //----------------------------------------
  // control registers
  //----------------------------------------
  reg        enable;
  reg        master;
  reg        arb_lost;
  reg        arb_prev;
  reg  [7:0] shift_out;
  wire       wr_ctrl;
  wire       release_wr;
  wire       wait_cancel_wr;
  wire       disable_evt;
  wire       arb_rise;

  assign wr_ctrl        = reg_hit(wr, addr, `ADDR_BUS_CONTROL);
  assign release_wr     = wr_ctrl & wdata[`BIT_RELEASE];
  assign wait_cancel_wr = wr_ctrl & wdata[`BIT_WAIT_CANCEL];
  assign disable_evt    = wr_ctrl & enable & ~wdata[`BIT_ENABLE];
  assign arb_rise       = arb_lost & ~arb_prev;

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      enable    <= 1'b0;
      master    <= 1'b0;
      arb_lost  <= 1'b0;
      arb_prev  <= 1'b0;
      shift_out <= `CTRL_RESET;
    end
    else
    begin
      arb_prev <= arb_lost;
      if (wr_ctrl)
        enable <= wdata[`BIT_ENABLE];
      if (reg_hit(wr, addr, `ADDR_ROLE_CTRL))
      begin
        master   <= wdata[`BIT_MASTER];
        arb_lost <= wdata[`BIT_ARB_LOST];
      end
      if (reg_hit(wr, addr, `ADDR_SHIFT_OUT))
        shift_out <= wdata;
    end
  end

  //----------------------------------------
  // bit counter and byte tracking
  //----------------------------------------
  reg  [3:0] bit_cnt;
  reg        first_byte;
  reg        addr_pending;
  reg        lsb_bit;
  wire       first_rise;
  wire       lsb_rise;
  wire       ninth_rise;
  wire       ninth_fall;

  // a byte starts from idle after start or from the ack slot
  assign first_rise = scl_rise & (at_pos(bit_cnt, `BIT_COUNT_FIRST) | (bit_cnt == `BIT_COUNT_ACK));
  assign lsb_rise   = scl_rise & at_pos(bit_cnt, `BIT_COUNT_LSB);
  assign ninth_rise = scl_rise & at_pos(bit_cnt, `BIT_COUNT_ACK);
  assign ninth_fall = scl_fall & (bit_cnt == `BIT_COUNT_ACK);

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      bit_cnt      <= 4'h0;
      first_byte   <= 1'b0;
      addr_pending <= 1'b0;
      lsb_bit      <= 1'b0;
    end
    else if (start_cond | stop_cond | ~enable)
    begin
      bit_cnt      <= 4'h0;
      first_byte   <= start_cond & enable;
      addr_pending <= start_cond & enable;
      lsb_bit      <= 1'b0;
    end
    else
    begin
      if (scl_rise)
        bit_cnt <= (bit_cnt == `BIT_COUNT_ACK) ? `BIT_COUNT_FIRST : bit_cnt + 4'h1;
      if (lsb_rise)
        lsb_bit <= sda_sync[1];
      if (first_rise)
        addr_pending <= 1'b0;
      if (ninth_fall)
        first_byte <= 1'b0;
    end
  end

  //----------------------------------------
  // status flags, set by bus events, cleared by bus events or control writes
  //----------------------------------------
  reg  direction_flag;
  reg  ack_detected_flag;
  reg  start_detected_flag;
  reg  stop_detected_flag;
  reg  drive_en;
  wire common_clr;
  wire master_lsb_one;

  assign common_clr     = stop_cond | release_wr | disable_evt;
  assign master_lsb_one = master & first_byte & lsb_rise & shift_out[0];

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      direction_flag      <= 1'b0;
      ack_detected_flag   <= 1'b0;
      start_detected_flag <= 1'b0;
      stop_detected_flag  <= 1'b0;
      drive_en            <= 1'b0;
    end
    else
    begin
      if (common_clr | wait_cancel_wr | arb_rise)
        direction_flag <= 1'b0;
      else if (~master & start_cond)
        direction_flag <= 1'b0;
      else if (master_lsb_one)
        direction_flag <= 1'b1;
      else if (~master & first_byte & lsb_rise)
        direction_flag <= sda_sync[1];

      if (common_clr | wait_cancel_wr | arb_rise | ~direction_flag)
        drive_en <= 1'b0;
      else if (first_byte & ninth_fall)
        drive_en <= 1'b1;

      // set wins over clear on the same cycle
      if (ninth_rise & ~sda_sync[1] & enable)
        ack_detected_flag <= 1'b1;
      else if (common_clr | first_rise)
        ack_detected_flag <= 1'b0;

      if (start_cond & enable)
        start_detected_flag <= 1'b1;
      else if (common_clr | (first_rise & ~addr_pending))
        start_detected_flag <= 1'b0;

      if (stop_cond & enable)
        stop_detected_flag <= 1'b1;
      else if (disable_evt | (first_rise & addr_pending))
        stop_detected_flag <= 1'b0;
    end
  end

  //----------------------------------------
  // data line drive
  //----------------------------------------
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      serial_data_line_out <= 1'b0;
      serial_data_line_oe  <= 1'b0;
    end
    else
    begin
      serial_data_line_out <= 1'b0;
      serial_data_line_oe  <= drive_en & direction_flag & ~shift_out[7];
    end
  end

  //----------------------------------------
  // register read, status is read-only
  //----------------------------------------
  reg [7:0] next_rdata;

  always @*
  begin
    next_rdata = `BYTE_ZERO;
    case (addr)
      `ADDR_BUS_STATUS:
      begin
        next_rdata[`BIT_DIR]   = direction_flag;
        next_rdata[`BIT_ACK]   = ack_detected_flag;
        next_rdata[`BIT_START] = start_detected_flag;
        next_rdata[`BIT_STOP]  = stop_detected_flag;
      end
      `ADDR_BUS_CONTROL:
        next_rdata[`BIT_ENABLE] = enable;
      `ADDR_ROLE_CTRL:
      begin
        next_rdata[`BIT_MASTER]   = master;
        next_rdata[`BIT_ARB_LOST] = arb_lost;
      end
      `ADDR_SHIFT_OUT:
        next_rdata = shift_out;
      default:
        next_rdata = `BYTE_ZERO;
    endcase
  end

  // read data stands one cycle only
  always @(posedge clk_sys)
  begin
    if (!rstn)
      rdata <= `BYTE_ZERO;
    else if (rd)
      rdata <= next_rdata;
    else
      rdata <= `BYTE_ZERO;
  end

endmodule

// >>> dv/i2c_status_flags_chk.sv
// port assertions of the status flag block
// assumes it is bound into i2c_status_flags
`timescale 1ns/1ns
module i2c_status_flags_chk
(
  input wire       clk_sys,
  input wire       rstn,
  input wire [1:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata,
  input wire       serial_clock_line,
  input wire       serial_data_line_out,
  input wire       serial_data_line_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  chk_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not idle");
  chk_drive_low: assert property (serial_data_line_oe |-> !serial_data_line_out)
    else $error("data line driven high");
  chk_drive_scl_low: assert property ($rose(serial_data_line_oe) |-> !serial_clock_line)
    else $error("drive began with clock high");
  chk_wait_release: assert property (wr && addr == 2'h1 && wdata[5] |-> ##[1:3] !serial_data_line_oe)
    else $error("wait cancel kept data driven");
  chk_release_off: assert property (wr && addr == 2'h1 && wdata[6] |-> ##[1:3] !serial_data_line_oe)
    else $error("release kept data driven");
  chk_ctrl_actions: assert property (rd && addr == 2'h1 |=> rdata[6:5] == 2'b00)
    else $error("action bits read back set");
  chk_disable_clr: assert property (wr && addr == 2'h1 && !wdata[7] ##2 rd && addr == 2'h0
    |=> rdata[3:0] == 4'h0)
    else $error("flags survive disable");
  chk_release_clr: assert property (wr && addr == 2'h1 && wdata[6] ##2 rd && addr == 2'h0
    |=> rdata[3:1] == 3'h0)
    else $error("flags survive release");
endmodule
bind i2c_status_flags i2c_status_flags_chk i2c_status_flags_chk_inst (.clk_sys, .rstn, .addr, .wdata,
  .wr, .rd, .rdata, .serial_clock_line, .serial_data_line_out, .serial_data_line_oe);

// >>> dv/i2c_far_end.sv
// far-side bus party: makes the bus clock, pulls data low
// assumes pull-ups on both lines, tasks called by the bench
`timescale 1ns/1ns
module i2c_far_end
(
  output logic scl,
  output logic sda_low
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic start;
  begin
    #3;
    sda_low = 1'b0;
    #20 scl = 1'b1;
    #20 sda_low = 1'b1;
    #20 scl = 1'b0;
    #20;
  end
  endtask
  task automatic stop;
  begin
    #3;
    sda_low = 1'b1;
    #20 scl = 1'b1;
    #20 sda_low = 1'b0;
    #40;
  end
  endtask
  // nine bits msb first, last one is the ack slot
  task automatic xfer(input logic [8:0] b);
  begin
    #3;
    for (int i = 8; i >= 0; i--)
    begin
      sda_low = !b[i];
      #20 scl = 1'b1;
      #40 scl = 1'b0;
      #20;
    end
    sda_low = 1'b0;
  end
  endtask
endmodule

// >>> dv/i2c_status_flags_tb.sv
// self-checking bench of the status flag block
// assumes the far-side model and the bound checker
`timescale 1ns/1ns
module i2c_status_flags_tb;
  logic        clk_sys, rstn, wr, rd, rd_q, sdo, sdoe;
  logic [1:0]  addr;
  logic [7:0]  wdata, rdata;
  logic [15:0] notes[$], note;
  logic [31:0] r;
  int          error_cnt, compares, cyc;
  wire         scl, sda_low;
  wire         sda = !(sda_low || (sdoe && !sdo));
  i2c_status_flags i2c_status_flags_inst (.clk_sys, .rstn, .addr, .wdata, .wr, .rd, .rdata,
    .serial_clock_line(scl), .serial_data_line_in(sda), .serial_data_line_out(sdo), .serial_data_line_oe(sdoe));
  i2c_far_end i2c_far_end_inst (.scl, .sda_low);
  // ----------------------------------------
  // tasks and result watcher
  // ----------------------------------------
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
  begin
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  end
  endtask
  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
  begin
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  end
  endtask
  task automatic rreg(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
  begin
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    notes.push_back({m, e});
    @(posedge clk_sys);
    rd <= 1'b0;
  end
  endtask
  task print_verdict;
  begin
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  always @(posedge clk_sys)
  begin
    rd_q <= rd;
    if (rd_q)
    begin
      note = notes.pop_front();
      cmp(rdata & note[15:8], note[7:0]);
    end
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      print_verdict;
    end
  end
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = !clk_sys;
  end
  initial
  begin
    {rstn, wr, rd, addr, wdata} = '0;
    r = $urandom(32'hABD6);
    r = $urandom;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rreg(2'h0, 8'h0F, 8'h00);
    rreg(2'h1, 8'hFF, 8'h00);
    wreg(2'h1, 8'h80);
    wreg(2'h0, r[31:24]);
    rreg(2'h1, 8'hE0, 8'h80);
    rreg(2'h0, 8'h0F, 8'h00);
    i2c_far_end_inst.start;
    rreg(2'h0, 8'h0F, 8'h02);
    i2c_far_end_inst.xfer({r[6:0], 2'b10});
    rreg(2'h0, 8'h0F, 8'h0E);
    repeat (8) @(posedge clk_sys);
    cmp({7'h00, sdoe}, 8'h01);
    wreg(2'h1, 8'hA0);
    rreg(2'h0, 8'h0F, 8'h06);
    i2c_far_end_inst.xfer({r[15:8], 1'b1});
    rreg(2'h0, 8'h0F, 8'h00);
    i2c_far_end_inst.stop;
    rreg(2'h0, 8'h0F, 8'h01);
    wreg(2'h1, 8'hC0);
    rreg(2'h0, 8'h0F, 8'h01);
    i2c_far_end_inst.start;
    rreg(2'h0, 8'h0F, 8'h03);
    i2c_far_end_inst.xfer({r[22:16], 2'b00});
    rreg(2'h0, 8'h0F, 8'h06);
    i2c_far_end_inst.stop;
    wreg(2'h2, 8'h01);
    wreg(2'h3, 8'h01);
    i2c_far_end_inst.start;
    i2c_far_end_inst.xfer({r[30:24], 2'b00});
    rreg(2'h0, 8'h0F, 8'h0E);
    wreg(2'h2, 8'h03);
    rreg(2'h0, 8'h0F, 8'h06);
    wreg(2'h1, 8'h00);
    rreg(2'h0, 8'h0F, 8'h00);
    repeat (2) @(posedge clk_sys);
    print_verdict;
  end
endmodule
